/* core/uart_ctl_pkg.sv */
// Constants, types and encodings shared by the serial port control block
// Behaviour
// R1: Reset loads the serial control register with 16H.
// R2: Break trigger clears whenever a communication completes with an interrupt.
// R3: Break status flag is 1 during break reception; cleared when disabled or done.
// R4: Bit order field picks MSB or LSB first; inversion field inverts transmit pin.
// R5: Software clears both enables before changing bit order or inversion.
// R6: Break trigger always reads 0 and self-clears after correct break reception.
// R7: Software sets break trigger only with power gate and receive enable set.
// R8: Control register bits 2 to 5 and 7 ignore writes.
// R9: After a break error, stay in break reception and keep the status flag.
// R10: Input switch register clears on reset and selects the receiver input.
// R11: Port 1 direction bit 0 drives the pin, 1 is input; all set on reset.
// R12: Software makes transmit pin an output latched 1, receive pin an input.
// R13: All three enables off stops the port and frees both pins.
// R14: Reset loads the operation mode register with 01H.
// R15: Power gate 0 holds the internal logic in asynchronous reset.
// R16: Transmit enable 0 disables and synchronously resets the transmitter.
// R17: Receive enable 0 disables and synchronously resets the receiver.
// R18: Power gate 0 drives transmit output high and sees receive input high.
// R19: Software clears enables before power gate; sets power gate before enables.
// R20: Software configures format, then power gate, then enables, then writes data.
// R21: Serial functions own a pin only when power gate and its enable are set.
// R22: Full duplex byte transfer after a start bit with its own baud generator.
// R23: Transmit inversion is the last stage before the transmit pin.
package uart_ctl_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] OPMODE_ADDR = 16'hFF50;
  localparam logic [15:0] SCTL_ADDR = 16'hFF58;
  localparam logic [15:0] P1DIR_ADDR = 16'hFF30;
  localparam logic [15:0] P1LAT_ADDR = 16'hFF31;
  localparam logic [15:0] ISW_ADDR = 16'hFF32;
  localparam logic [15:0] TXBUF_ADDR = 16'hFF33;
  localparam logic [15:0] RXBUF_ADDR = 16'hFF34;
  localparam logic [15:0] TXSTAT_ADDR = 16'hFF35;
  localparam logic [15:0] RXERR_ADDR = 16'hFF36;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] OPMODE_RESET = 8'h01;
  localparam logic [7:0] SCTL_RESET = 8'h16;
  localparam logic [7:0] P1DIR_RESET = 8'hFF;
  localparam logic [7:0] P1LAT_RESET = 8'h00;
  localparam logic [7:0] ISW_RESET = 8'h00;
  localparam int SCTL_FLAG_BIT = 7;
  localparam int SCTL_TRIG_BIT = 6;
  localparam int SCTL_DIR_BIT = 1;
  localparam int SCTL_INV_BIT = 0;
  localparam int TX_PIN_IDX = 3;
  localparam int RX_PIN_IDX = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 125000000;
  localparam int BAUD_HZ = 115200;
  localparam logic [15:0] BAUD_DIV_DEF = 16'(CLK_HZ / BAUD_HZ);
  localparam logic [3:0] BREAK_MIN_BITS = 4'hB;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic power_gate;
    logic transmit_enable;
    logic receive_enable;
    logic [4:0] frame_fmt;
  } opmode_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b10,
    TX_STOP = 2'b11
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_STOP = 3'b011,
    RX_BRK_WAIT = 3'b100,
    RX_BRK_LOW = 3'b101
  } rx_state_t;

endpackage

/* core/uart_tx_shift.sv */
// Transmit serialiser: start bit, eight data bits, one stop bit
module uart_tx_shift
  import uart_ctl_pkg::*;
(
  // Clock and resets
  input wire logic mclk,
  input wire logic rst,
  input wire logic clr,
  // Control
  input wire logic tick,
  input wire logic start,
  input wire logic [7:0] data,
  input wire logic lsb_first,
  // Status and line
  output logic busy,
  output logic line,
  output logic done
);

  tx_state_t state_reg;
  logic [7:0] sh_reg;
  logic [2:0] cnt_reg;

  assign busy = (state_reg != TX_IDLE);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= TX_IDLE;
      sh_reg <= 8'h00;
      cnt_reg <= 3'h0;
      line <= 1'b1;
      done <= 1'b0;
    end else if (clr) begin // [R16]
      state_reg <= TX_IDLE;
      line <= 1'b1;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        TX_IDLE: if (start && tick) begin
          // Always shift out bit 0; MSB-first data is reversed on load
          sh_reg <= lsb_first ? data : {<<{data}}; // [R4]
          line <= 1'b0;
          state_reg <= TX_START;
        end
        TX_START: if (tick) begin
          line <= sh_reg[0];
          sh_reg <= {1'b0, sh_reg[7:1]};
          cnt_reg <= 3'h0;
          state_reg <= TX_DATA;
        end
        TX_DATA: if (tick) begin
          if (cnt_reg == 3'h7) begin
            line <= 1'b1;
            state_reg <= TX_STOP;
          end else begin
            line <= sh_reg[0];
            sh_reg <= {1'b0, sh_reg[7:1]};
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
        TX_STOP: if (tick) begin
          done <= 1'b1;
          state_reg <= TX_IDLE;
        end
        default: state_reg <= TX_IDLE;
      endcase
    end
  end

endmodule // uart_tx_shift

/* core/uart_rx_shift.sv */
// Receive deserialiser with break field detection
module uart_rx_shift
  import uart_ctl_pkg::*;
#(
  parameter logic [15:0] DIV = BAUD_DIV_DEF
) (
  // Clock and resets
  input wire logic mclk,
  input wire logic rst,
  input wire logic clr,
  // Control
  input wire logic rxd,
  input wire logic lsb_first,
  input wire logic brk_mode,
  // Results
  output logic [7:0] data,
  output logic byte_valid,
  output logic frame_err,
  output logic brk_ok,
  output logic brk_err
);

  rx_state_t state_reg;
  logic [15:0] cnt_reg;
  logic [3:0] bit_reg;
  logic half;
  logic full;

  assign half = (cnt_reg == {1'b0, DIV[15:1]});
  assign full = (cnt_reg == DIV - 16'h1);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= RX_IDLE;
      cnt_reg <= 16'h0000;
      bit_reg <= 4'h0;
      data <= 8'h00;
      {byte_valid, frame_err, brk_ok, brk_err} <= 4'h0;
    end else if (clr) begin // [R17]
      state_reg <= RX_IDLE;
      cnt_reg <= 16'h0000;
      {byte_valid, frame_err, brk_ok, brk_err} <= 4'h0;
    end else begin
      {byte_valid, frame_err, brk_ok, brk_err} <= 4'h0;
      cnt_reg <= full ? 16'h0000 : cnt_reg + 16'h1;
      case (state_reg)
        RX_IDLE: begin
          cnt_reg <= 16'h0000;
          if (brk_mode) state_reg <= RX_BRK_WAIT;
          else if (!rxd) state_reg <= RX_START;
        end
        RX_START: if (half) begin
          cnt_reg <= 16'h0000;
          bit_reg <= 4'h0;
          state_reg <= rxd ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (full) begin
          data <= lsb_first ? {rxd, data[7:1]} : {data[6:0], rxd}; // [R4]
          bit_reg <= bit_reg + 4'h1;
          if (bit_reg == 4'h7) state_reg <= RX_STOP;
        end
        RX_STOP: if (full) begin
          byte_valid <= 1'b1;
          frame_err <= !rxd;
          state_reg <= RX_IDLE;
        end
        RX_BRK_WAIT: begin
          cnt_reg <= 16'h0000;
          bit_reg <= 4'h0;
          if (!brk_mode) state_reg <= RX_IDLE;
          else if (!rxd) state_reg <= RX_BRK_LOW;
        end
        RX_BRK_LOW: begin
          if (full && bit_reg != 4'hF) bit_reg <= bit_reg + 4'h1;
          if (rxd) begin
            // A short low is an error; stay armed for the next break
            brk_ok <= (bit_reg >= BREAK_MIN_BITS);
            brk_err <= (bit_reg < BREAK_MIN_BITS);
            state_reg <= (bit_reg >= BREAK_MIN_BITS) ? RX_IDLE : RX_BRK_WAIT; // [R9]
          end
        end
        default: state_reg <= RX_IDLE;
      endcase
    end
  end

endmodule // uart_rx_shift

/* core/uart_control.sv */
// Serial port control, enables, break reception and port 1 pin routing
module uart_control
  import uart_ctl_pkg::*;
#(
  parameter logic [15:0] BAUD_DIV = BAUD_DIV_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register access
  input wire bus_req_t req,
  output logic [7:0] rdata,
  // Port 1 pins
  input wire logic [7:0] port1_in,
  output logic [7:0] port1_out,
  output logic [7:0] port1_oe,
  // Alternate receive source for LIN status
  input wire logic lin_alt_in
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  opmode_t opmode_reg;
  logic dir_reg;
  logic inv_reg;
  logic trig_reg;
  logic flag_reg;
  logic [7:0] p1dir_reg;
  logic [7:0] p1lat_reg;
  logic [7:0] isw_reg;
  logic [7:0] txbuf_reg;
  logic txbuf_full_reg;
  logic [7:0] rxbuf_reg;
  logic [1:0] rxerr_reg;
  logic [15:0] baud_cnt_reg;
  logic tick_reg;
  logic rx_in_reg;

  logic core_rst;
  logic power;
  logic tx_route;
  logic rx_route;
  logic tx_take;
  logic tx_busy;
  logic tx_line;
  logic tx_done;
  logic tx_pin_val;
  logic rx_src;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_ferr;
  logic brk_ok;
  logic brk_err;
  logic comm_done;
  logic trig_set;
  logic wr_op;
  logic wr_sctl;
  logic wr_p1dir;
  logic wr_p1lat;
  logic wr_isw;
  logic wr_txb;
  logic rd_rxerr;

  // ----------------------------------------------------------------
  // Decode and control terms
  // ----------------------------------------------------------------
  assign wr_op = req.wr && (req.addr == OPMODE_ADDR);
  assign wr_sctl = req.wr && (req.addr == SCTL_ADDR);
  assign wr_p1dir = req.wr && (req.addr == P1DIR_ADDR);
  assign wr_p1lat = req.wr && (req.addr == P1LAT_ADDR);
  assign wr_isw = req.wr && (req.addr == ISW_ADDR);
  assign wr_txb = req.wr && (req.addr == TXBUF_ADDR);
  assign rd_rxerr = req.rd && (req.addr == RXERR_ADDR);

  assign power = opmode_reg.power_gate;
  // Combinational OR of rst and the power gate flop, not a flop of its own
  assign core_rst = rst || !power; // [R15]
  assign tx_route = power && opmode_reg.transmit_enable; // [R21] [R13]
  assign rx_route = power && opmode_reg.receive_enable; // [R21] [R13]
  assign comm_done = tx_done || rx_valid || brk_ok;
  assign trig_set = wr_sctl && req.wdata[SCTL_TRIG_BIT] && rx_route;
  assign tx_take = txbuf_full_reg && !tx_busy && tick_reg;

  // ----------------------------------------------------------------
  // Operation mode register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      opmode_reg <= opmode_t'(OPMODE_RESET); // [R14]
    end else if (wr_op) begin
      opmode_reg <= opmode_t'(req.wdata);
    end
  end

  // ----------------------------------------------------------------
  // Serial control register
  // ----------------------------------------------------------------
  // Bit order and inversion load here; trigger bit 6 and flag bit 7 are set below, bits 2 to 5 are fixed
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dir_reg <= SCTL_RESET[SCTL_DIR_BIT]; // [R1]
      inv_reg <= SCTL_RESET[SCTL_INV_BIT]; // [R1]
    end else if (wr_sctl) begin // [R8]
      dir_reg <= req.wdata[SCTL_DIR_BIT];
      inv_reg <= req.wdata[SCTL_INV_BIT];
    end
  end

  // Set wins over every clear so a rewrite re-arms reception
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      trig_reg <= SCTL_RESET[SCTL_TRIG_BIT]; // [R15]
    end else if (trig_set) begin
      trig_reg <= 1'b1;
    end else if (comm_done || !opmode_reg.receive_enable) begin // [R2] [R6]
      trig_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      flag_reg <= SCTL_RESET[SCTL_FLAG_BIT]; // [R15] [R3]
    end else if (trig_set) begin
      flag_reg <= 1'b1; // [R3]
    end else if (brk_ok || !opmode_reg.receive_enable) begin // [R3]
      flag_reg <= 1'b0;
    end
    // A break error leaves the flag as it stands [R9]
  end

  // ----------------------------------------------------------------
  // Port and input switch registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      p1dir_reg <= P1DIR_RESET; // [R11]
      p1lat_reg <= P1LAT_RESET;
      isw_reg <= ISW_RESET; // [R10]
    end else begin
      if (wr_p1dir) p1dir_reg <= req.wdata;
      if (wr_p1lat) p1lat_reg <= req.wdata;
      if (wr_isw) isw_reg <= req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Dedicated baud generator
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      baud_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (baud_cnt_reg == BAUD_DIV - 16'h1); // [R22]
      if (baud_cnt_reg == BAUD_DIV - 16'h1) begin
        baud_cnt_reg <= 16'h0000;
      end else begin
        baud_cnt_reg <= baud_cnt_reg + 16'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------
  // Writes with transmit disabled are dropped
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      txbuf_reg <= 8'h00;
      txbuf_full_reg <= 1'b0;
    end else if (!opmode_reg.transmit_enable) begin // [R16]
      txbuf_full_reg <= 1'b0;
    end else if (wr_txb) begin // [R20]
      txbuf_reg <= req.wdata;
      txbuf_full_reg <= 1'b1;
    end else if (tx_take) begin
      txbuf_full_reg <= 1'b0;
    end
  end

  uart_tx_shift u_tx (
    .mclk(mclk),
    .rst(core_rst),
    .clr(!opmode_reg.transmit_enable),
    .tick(tick_reg),
    .start(txbuf_full_reg),
    .data(txbuf_reg),
    .lsb_first(dir_reg),
    .busy(tx_busy),
    .line(tx_line),
    .done(tx_done)
  );

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  assign rx_src = isw_reg[0] ? lin_alt_in : port1_in[RX_PIN_IDX]; // [R10]

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_in_reg <= 1'b1;
    end else begin
      rx_in_reg <= rx_route ? rx_src : 1'b1; // [R18] [R21]
    end
  end

  uart_rx_shift #(
    .DIV(BAUD_DIV)
  ) u_rx (
    .mclk(mclk),
    .rst(core_rst),
    .clr(!opmode_reg.receive_enable),
    .rxd(rx_in_reg),
    .lsb_first(dir_reg),
    .brk_mode(trig_reg),
    .data(rx_data),
    .byte_valid(rx_valid),
    .frame_err(rx_ferr),
    .brk_ok(brk_ok),
    .brk_err(brk_err)
  );

  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      rxbuf_reg <= 8'h00; // [R15]
    end else if (rx_valid) begin
      rxbuf_reg <= rx_data;
    end
  end

  // Reading clears the errors; a new error in that cycle still lands
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      rxerr_reg <= 2'b00; // [R15]
    end else begin
      rxerr_reg[0] <= (rx_valid && rx_ferr) || (rxerr_reg[0] && !rd_rxerr);
      rxerr_reg[1] <= brk_err || (rxerr_reg[1] && !rd_rxerr);
    end
  end

  // ----------------------------------------------------------------
  // Pin routing
  // ----------------------------------------------------------------
  // Inversion sits after idle forcing so an inverted line idles low
  assign tx_pin_val = (power ? tx_line : 1'b1) ^ inv_reg; // [R18] [R23] [R4]

  for (genvar n = 0; n < 8; n++) begin : g_pin
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        port1_out[n] <= P1LAT_RESET[n];
        port1_oe[n] <= !P1DIR_RESET[n];
      end else begin
        if (n == TX_PIN_IDX && tx_route) begin
          port1_out[n] <= tx_pin_val; // [R21]
        end else begin
          port1_out[n] <= p1lat_reg[n]; // [R13]
        end
        port1_oe[n] <= !p1dir_reg[n]; // [R11]
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        OPMODE_ADDR: rdata <= opmode_reg;
        // Trigger always reads zero [R6]
        SCTL_ADDR: rdata <= {flag_reg, 1'b0, SCTL_RESET[5:2], dir_reg, inv_reg};
        P1DIR_ADDR: rdata <= p1dir_reg;
        P1LAT_ADDR: rdata <= p1lat_reg;
        ISW_ADDR: rdata <= isw_reg;
        TXBUF_ADDR: rdata <= txbuf_reg;
        RXBUF_ADDR: rdata <= rxbuf_reg;
        TXSTAT_ADDR: rdata <= {6'h00, txbuf_full_reg, tx_busy};
        RXERR_ADDR: rdata <= {6'h00, rxerr_reg};
        default: rdata <= 8'h00;
      endcase
    end
  end

endmodule // uart_control

/* testbench/uart_control_chk.sv */
// Port-level assertions for the serial port control block
module uart_control_chk
  import uart_ctl_pkg::*;
#(
  parameter logic [15:0] BAUD_DIV = BAUD_DIV_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register access
  input wire bus_req_t req,
  input wire logic [7:0] rdata,
  // Pins
  input wire logic [7:0] port1_in,
  input wire logic [7:0] port1_out,
  input wire logic [7:0] port1_oe,
  input wire logic lin_alt_in
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TX_WAIT = 2 * BAUD_DIV + 4;
  logic [7:0] op_reg;
  logic [7:0] dir_reg;
  logic [7:0] lat_reg;
  logic [1:0] ctl_reg;
  logic route;
  assign route = op_reg[7] && op_reg[6];
  // ----------------------------------------------------------------
  // Shadow copies of the mode, port direction, port latch and control bit 1 to 0 fields
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      op_reg <= OPMODE_RESET;
      dir_reg <= P1DIR_RESET;
      lat_reg <= P1LAT_RESET;
      ctl_reg <= SCTL_RESET[1:0];
    end else if (req.wr) begin
      if (req.addr == OPMODE_ADDR) op_reg <= req.wdata;
      if (req.addr == P1DIR_ADDR) dir_reg <= req.wdata;
      if (req.addr == P1LAT_ADDR) lat_reg <= req.wdata;
      if (req.addr == SCTL_ADDR) ctl_reg <= req.wdata[1:0];
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence rd_of(logic [15:0] a);
    req.rd && req.addr == a;
  endsequence
  // Only valid with the transmitter idle; the bench never queues a second byte
  sequence tx_kick;
    route && $past(route) && req.wr && req.addr == TXBUF_ADDR;
  endsequence
  sequence start_bit;
    ##[1:TX_WAIT] (port1_out[3] == ctl_reg[0])[*4];
  endsequence
  sctl_fixed_a:
    assert property (rd_of(SCTL_ADDR) |=> rdata[6:0] == {5'h05, ctl_reg})
    else $error("control readback wrong");
  flag_off_a:
    assert property (rd_of(SCTL_ADDR) ##0 (!op_reg[5] && !$past(op_reg[5])) |=> !rdata[7])
    else $error("break flag set while receive disabled");
  op_read_a:
    assert property (rd_of(OPMODE_ADDR) |=> rdata == op_reg)
    else $error("mode register readback wrong");
  dir_read_a:
    assert property (rd_of(P1DIR_ADDR) |=> rdata == dir_reg)
    else $error("direction readback wrong");
  rxbuf_clear_a:
    assert property (rd_of(RXBUF_ADDR) ##0 (!op_reg[7] && !$past(op_reg[7])) |=> rdata == 8'h00)
    else $error("receive buffer kept while gated off");
  pin_dir_a:
    assert property ($stable(dir_reg)[*2] |-> port1_oe == ~dir_reg)
    else $error("output enable does not follow direction");
  port_latch_a:
    assert property ((!route && $stable(lat_reg))[*2] |-> port1_out == lat_reg)
    else $error("pins not released to the latch");
  tx_start_a:
    assert property (tx_kick |-> start_bit)
    else $error("start bit missing after buffer write");
endmodule // uart_control_chk

bind uart_control uart_control_chk #(.BAUD_DIV(BAUD_DIV)) i_chk (
  .mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .port1_in(port1_in),
  .port1_out(port1_out), .port1_oe(port1_oe), .lin_alt_in(lin_alt_in)
);

/* testbench/uart_remote_node.sv */
// Remote serial node model on the far side of the serial pins
module uart_remote_node
  import uart_ctl_pkg::*;
#(
  parameter int BIT_CYC = 8
) (
  // Clock
  input wire logic mclk,
  // Line from the device and line towards it
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic inv_cfg = 1'b0;
  logic lsb_cfg = 1'b0;
  logic listen = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  int rx_cnt = 0;
  initial line_out = 1'b1;
  // ----------------------------------------------------------------
  // Line driving, always push-pull, idle high
  // ----------------------------------------------------------------
  task automatic drive(input logic v, input int n);
    line_out <= v;
    repeat (n) @(posedge mclk);
  endtask
  task automatic send_byte(input logic [7:0] v);
    drive(1'b0, BIT_CYC);
    for (int i = 0; i < 8; i++) drive(lsb_cfg ? v[i] : v[7 - i], BIT_CYC);
    drive(1'b1, BIT_CYC);
  endtask
  // Too short a low makes a break error, the device must stay armed
  task automatic send_low(input int bits);
    drive(1'b0, bits * BIT_CYC);
    drive(1'b1, 2 * BIT_CYC);
  endtask
  // ----------------------------------------------------------------
  // Frame monitor, sampled mid-bit
  // ----------------------------------------------------------------
  always begin
    @(posedge mclk);
    if (listen && (line_in ^ inv_cfg) == 1'b0) begin
      repeat (BIT_CYC / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge mclk);
        rx_byte[lsb_cfg ? i : 7 - i] = line_in ^ inv_cfg;
      end
      repeat (BIT_CYC) @(posedge mclk);
      rx_cnt++;
    end
  end
endmodule // uart_remote_node

/* testbench/test_uart_control_and_enable.sv */
// Self-checking bench for the serial port control block
module test_uart_control_and_enable
  import uart_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] DIV = 16'h0008;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  bus_req_t req = '0;
  logic [7:0] rdata;
  logic [7:0] port1_out;
  logic [7:0] port1_oe;
  logic [7:0] pins;
  logic node_tx;
  logic lin_sel = 1'b0;
  logic [31:0] seed = 32'h6AEED6D8;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  always #4 mclk = ~mclk;
  // Undriven pins sit high on pull-ups; alternate input carries the node when selected
  assign pins = (port1_oe & port1_out) | (~port1_oe & {3'b111, lin_sel | node_tx, 4'hF});
  uart_control #(.BAUD_DIV(DIV)) i_dut (
    .mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .port1_in(pins),
    .port1_out(port1_out), .port1_oe(port1_oe), .lin_alt_in(~lin_sel | node_tx)
  );
  uart_remote_node #(.BIT_CYC(int'(DIV))) i_node (
    .mclk(mclk), .line_in(pins[3]), .line_out(node_tx)
  );
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] sctl_exp(input logic flag, input logic dir, input logic inv);
    return {flag, 5'h05, dir, inv};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge mclk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge mclk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 check(rdata, exp);
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(OPMODE_ADDR, OPMODE_RESET);
    rd_chk(SCTL_ADDR, SCTL_RESET);
    rd_chk(P1DIR_ADDR, P1DIR_RESET);
    rd_chk(ISW_ADDR, ISW_RESET);
    check(port1_oe, 8'h00);
    wr(SCTL_ADDR, 8'hA3);
    rd_chk(SCTL_ADDR, sctl_exp(1'b0, 1'b1, 1'b1));
    seed = lfsr(seed);
    wr(P1DIR_ADDR, seed[7:0] & 8'hF7 | 8'h10);
    wr(P1LAT_ADDR, seed[15:8] | 8'h08);
    repeat (2) @(posedge mclk);
    check(port1_oe, ~(seed[7:0] & 8'hF7 | 8'h10));
    check(port1_out, seed[15:8] | 8'h08);
    // Every bit order and inversion, with either receive source
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk) lin_sel <= m[0];
      wr(ISW_ADDR, {7'h00, m[0]});
      wr(SCTL_ADDR, {6'h05, m[1], m[0]});
      seed = lfsr(seed);
      wr(OPMODE_ADDR, {3'b000, seed[4:0]});
      wr(OPMODE_ADDR, {3'b100, seed[4:0]});
      wr(OPMODE_ADDR, {3'b111, seed[4:0]});
      repeat (3) @(posedge mclk);
      check({7'h00, pins[3]}, {7'h00, ~m[0]});
      i_node.inv_cfg = m[0];
      i_node.lsb_cfg = m[1];
      i_node.listen = 1'b1;
      fork
        wr(TXBUF_ADDR, seed[15:8]);
        i_node.send_byte(seed[23:16]);
      join
      for (int t = 0; t < 300 && i_node.rx_cnt <= m; t++) @(posedge mclk);
      check(i_node.rx_byte, seed[15:8]);
      rd_chk(RXBUF_ADDR, seed[23:16]);
      i_node.listen = 1'b0;
      wr(OPMODE_ADDR, {3'b100, seed[4:0]});
      wr(OPMODE_ADDR, {3'b000, seed[4:0]});
      repeat (2) @(posedge mclk);
      check({7'h00, port1_out[3]}, 8'h01);
      rd_chk(RXBUF_ADDR, 8'h00);
    end
    // Break field: short low is an error, long low completes
    @(posedge mclk) lin_sel <= 1'b0;
    wr(ISW_ADDR, 8'h00);
    wr(SCTL_ADDR, 8'h14);
    wr(OPMODE_ADDR, 8'h80);
    wr(OPMODE_ADDR, 8'hA0);
    wr(SCTL_ADDR, 8'h40);
    rd_chk(SCTL_ADDR, sctl_exp(1'b1, 1'b0, 1'b0));
    i_node.send_low(5);
    rd_chk(RXERR_ADDR, 8'h02);
    rd_chk(SCTL_ADDR, sctl_exp(1'b1, 1'b0, 1'b0));
    i_node.send_low(13);
    rd_chk(SCTL_ADDR, sctl_exp(1'b0, 1'b0, 1'b0));
    // A finished transmission disarms the trigger, so a short low is no break error
    wr(OPMODE_ADDR, 8'hE0);
    wr(SCTL_ADDR, 8'h40);
    wr(TXBUF_ADDR, seed[31:24]);
    repeat (100) @(posedge mclk);
    i_node.send_low(5);
    rd_chk(RXERR_ADDR, 8'h00);
    wr(SCTL_ADDR, 8'h40);
    wr(OPMODE_ADDR, 8'h80);
    rd_chk(SCTL_ADDR, sctl_exp(1'b0, 1'b0, 1'b0));
    report_and_stop();
  end
endmodule // test_uart_control_and_enable
